// file: ppg_pkg.sv
package ppg_pkg;

    // ************************************************************
    // Timebases
    // ************************************************************
    localparam int TB_NUM = 3;
    localparam int TB_W = 32;
    localparam int DIV_W = 9;
    localparam logic [TB_W-1:0] TB_WIDE_MAX = 32'hFFFF_FFFF;
    localparam logic [TB_W-1:0] TB_NARROW_MAX = 32'h0000_FFFF;
    localparam logic [DIV_W-1:0] DIV_ONE = 9'h001;

    // ************************************************************
    // Core tick rate derived from the system clock
    // ************************************************************
    localparam int SYS_CLK_MHZ = 100;
    localparam int CORE_TICK_MHZ = 80;
    localparam int ACC_W = 8;
    localparam logic [ACC_W-1:0] CORE_STEP = 8'(CORE_TICK_MHZ);
    localparam logic [ACC_W-1:0] SYS_MOD = 8'(SYS_CLK_MHZ);

    // ************************************************************
    // Register indices
    // ************************************************************
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_SELECT = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_OPTIONS = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_FALL = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_RISE = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_PULSES = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_RESULT = 3'h6;
    localparam logic [ADDR_W-1:0] ADDR_RESTART = 3'h7;

    // ************************************************************
    // Fields, codes and resets
    // ************************************************************
    localparam int EN_BIT = 0;
    localparam int OPT_SEL_W = 3;
    localparam logic [OPT_SEL_W-1:0] TB_SEL_COUNT = 3'h3;
    localparam logic [31:0] PHASE_INDEX = 32'h0000_0001;
    localparam logic [31:0] PULSE_INDEX = 32'h0000_0002;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [31:0] ONE_WORD = 32'h0000_0001;
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_CMP_EXCEEDS = 16'h0A05;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_RUN = 2'h1,
        SEQ_DONE = 2'h2
    } ppg_seq_t;

endpackage

// file: ppg_tb_if.sv
`timescale 1ns/10ps
interface ppg_tb_if;
    import ppg_pkg::*;
    logic core_tick;
    logic enable;
    logic [DIV_W-1:0] divider;
    logic [TB_W-1:0] wrap;
    logic [TB_W-1:0] wrap_max;
    logic [TB_W-1:0] count;
    logic [TB_W-1:0] wrap_eff;
    logic adv;
    logic period_start;
    modport tb (input core_tick, enable, divider, wrap, wrap_max, output count, wrap_eff, adv, period_start);
    modport user (output core_tick, enable, divider, wrap, wrap_max, input count, wrap_eff, adv, period_start);
endinterface

// file: ppg_timebase.sv
`timescale 1ns/10ps
module ppg_timebase
    import ppg_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Timebase link
    ppg_tb_if.tb tb
);

    logic [DIV_W-1:0] pre_q;
    logic [TB_W-1:0] count_q;
    logic [TB_W-1:0] wrap_q;
    logic adv_q;
    logic start_q;
    logic [DIV_W-1:0] div_last;
    logic [TB_W-1:0] wrap_in;

    // ************************************************************
    // Divider and wrap decode
    // ************************************************************
    // Zero behaves as divide by one
    assign div_last = (tb.divider <= DIV_ONE) ? '0 : tb.divider - DIV_ONE;
    // Zero wrap means the widest count
    assign wrap_in = ((tb.wrap & tb.wrap_max) == '0) ? tb.wrap_max : (tb.wrap & tb.wrap_max);

    // ************************************************************
    // Count
    // ************************************************************
    always_ff @(posedge clk_sys_in) begin
        adv_q <= 1'b0;
        start_q <= 1'b0;
        if (!rst_b_in) begin
            pre_q <= '0;
            count_q <= '0;
            wrap_q <= TB_WIDE_MAX;
        end else if (!tb.enable) begin
            pre_q <= '0;
            count_q <= '0;
            wrap_q <= wrap_in;
        end else if (tb.core_tick) begin
            if (pre_q >= div_last) begin
                pre_q <= '0;
                adv_q <= 1'b1;
                // New wrap waits for the period end so the running period stays whole
                if (count_q >= wrap_q - ONE_WORD) begin
                    count_q <= '0;
                    wrap_q <= wrap_in;
                    start_q <= 1'b1;
                end else begin
                    count_q <= count_q + ONE_WORD;
                end
            end else begin
                pre_q <= pre_q + DIV_ONE;
            end
        end
    end

    assign tb.count = count_q;
    assign tb.wrap_eff = wrap_q;
    assign tb.adv = adv_q;
    assign tb.period_start = start_q;

endmodule

// file: ppg_line.sv
`timescale 1ns/10ps
module ppg_line
    import ppg_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Timebase settings from the clock-source unit
    input wire logic [TB_NUM-1:0] tb_enable_in,
    input wire logic [TB_NUM-1:0][DIV_W-1:0] tb_divider_in,
    input wire logic [TB_NUM-1:0][TB_W-1:0] tb_wrap_in,
    // Register port
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic reg_err_out,
    output logic [15:0] reg_err_code_out,
    // Output line
    output logic line_out
);

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);

    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_sum;
    logic core_tick_q;
    logic [TB_NUM-1:0][TB_W-1:0] tb_count;
    logic [TB_NUM-1:0][TB_W-1:0] tb_wrap_eff;
    logic [TB_NUM-1:0] tb_adv;
    logic [TB_NUM-1:0] tb_start;
    logic enable_q;
    logic [31:0] select_q;
    logic [31:0] options_q;
    logic [31:0] fall_stage_q;
    logic [31:0] rise_stage_q;
    logic [31:0] fall_act_q;
    logic [31:0] rise_act_q;
    logic [31:0] total_q;
    logic [31:0] done_q;
    logic load_pend_q;
    logic line_q;
    logic [31:0] rdata_q;
    logic rvalid_q;
    logic err_q;
    logic [15:0] err_code_q;
    ppg_seq_t seq_q;

    // ************************************************************
    // Core tick: 80 of every 100 system cycles
    // ************************************************************
    assign acc_sum = acc_q + CORE_STEP;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            acc_q <= '0;
            core_tick_q <= 1'b0;
        end else if (acc_sum >= SYS_MOD) begin
            acc_q <= acc_sum - SYS_MOD;
            core_tick_q <= 1'b1;
        end else begin
            acc_q <= acc_sum;
            core_tick_q <= 1'b0;
        end
    end

    // ************************************************************
    // Timebases
    // ************************************************************
    ppg_tb_if tbi [TB_NUM] ();

    genvar g;
    generate
        for (g = 0; g < TB_NUM; g++) begin : g_tb
            assign tbi[g].core_tick = core_tick_q;
            assign tbi[g].enable = tb_enable_in[g];
            assign tbi[g].divider = tb_divider_in[g];
            assign tbi[g].wrap = tb_wrap_in[g];
            // Timebase zero is the wide one
            assign tbi[g].wrap_max = (g == 0) ? TB_WIDE_MAX : TB_NARROW_MAX;
            assign tb_count[g] = tbi[g].count;
            assign tb_wrap_eff[g] = tbi[g].wrap_eff;
            assign tb_adv[g] = tbi[g].adv;
            assign tb_start[g] = tbi[g].period_start;
            ppg_timebase u_tb (
                .clk_sys_in(clk_sys_in),
                .rst_b_in(rst_b_in),
                .tb(tbi[g])
            );
        end
    endgenerate

    // ************************************************************
    // Selection and decode
    // ************************************************************
    logic [OPT_SEL_W-1:0] tb_sel;
    logic sel_ok;
    logic [1:0] sel_idx;
    logic [TB_W-1:0] sel_cnt;
    logic [TB_W-1:0] sel_wrap;
    logic sel_adv;
    logic sel_start;
    logic sel_run;
    logic phase_mode;
    logic pulse_mode;
    logic wr_enable;
    logic wr_fall;
    logic wr_rise;
    logic wr_pulses;
    logic cmp_bad;
    logic enable_rise;
    logic rd_restart;
    logic load_now;
    logic seq_start;
    logic [31:0] total_next;
    logic [31:0] fall_cmp;
    logic [31:0] rise_cmp;

    // Unlisted codes select no timebase, so the line never moves
    assign tb_sel = options_q[OPT_SEL_W-1:0];
    assign sel_ok = tb_sel < TB_SEL_COUNT;
    assign sel_idx = tb_sel[1:0];
    assign sel_cnt = sel_ok ? tb_count[sel_idx] : '0;
    assign sel_wrap = sel_ok ? tb_wrap_eff[sel_idx] : '0;
    assign sel_adv = sel_ok && tb_adv[sel_idx];
    assign sel_start = sel_ok && tb_start[sel_idx];
    assign sel_run = sel_ok && tb_enable_in[sel_idx];
    assign phase_mode = select_q == PHASE_INDEX;
    assign pulse_mode = select_q == PULSE_INDEX;

    assign wr_enable = reg_wr_in && (reg_addr_in == ADDR_ENABLE);
    assign wr_fall = reg_wr_in && (reg_addr_in == ADDR_FALL);
    assign wr_rise = reg_wr_in && (reg_addr_in == ADDR_RISE);
    assign wr_pulses = reg_wr_in && (reg_addr_in == ADDR_PULSES);
    // Checked against the wrap in effect, not a pending one
    assign cmp_bad = reg_wdata_in > sel_wrap;
    assign enable_rise = wr_enable && reg_wdata_in[EN_BIT] && !enable_q;
    assign rd_restart = reg_rd_in && (reg_addr_in == ADDR_RESTART) && pulse_mode;
    // A stopped timebase has no period edge to wait for
    assign load_now = phase_mode && load_pend_q && (sel_start || !sel_run);
    assign seq_start = pulse_mode && (wr_pulses || rd_restart || enable_rise);
    assign total_next = wr_pulses ? reg_wdata_in : total_q;
    // Loaded values apply to the count 0 compare of the same period
    assign fall_cmp = load_now ? fall_stage_q : fall_act_q;
    assign rise_cmp = load_now ? rise_stage_q : rise_act_q;

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            enable_q <= 1'b0;
            select_q <= REG_RESET;
            options_q <= REG_RESET;
            total_q <= REG_RESET;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                ADDR_ENABLE: enable_q <= reg_wdata_in[EN_BIT];
                ADDR_SELECT: select_q <= reg_wdata_in;
                ADDR_OPTIONS: options_q <= reg_wdata_in;
                ADDR_PULSES: total_q <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Compare staging and load
    // ************************************************************
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            fall_stage_q <= REG_RESET;
            rise_stage_q <= REG_RESET;
        end else begin
            if (wr_fall && !cmp_bad) begin
                fall_stage_q <= reg_wdata_in;
            end
            if (wr_rise && !cmp_bad) begin
                rise_stage_q <= reg_wdata_in;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            load_pend_q <= 1'b0;
        end else if (wr_rise && !cmp_bad && phase_mode) begin
            // A fresh rise write wins over a load in the same cycle
            load_pend_q <= 1'b1;
        end else if (load_now) begin
            load_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            fall_act_q <= REG_RESET;
            rise_act_q <= REG_RESET;
        end else if (load_now || (pulse_mode && (wr_pulses || enable_rise))) begin
            fall_act_q <= fall_stage_q;
            rise_act_q <= rise_stage_q;
        end
    end

    // ************************************************************
    // Error report
    // ************************************************************
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            err_q <= 1'b0;
            err_code_q <= ERR_NONE;
        end else if ((wr_fall || wr_rise) && cmp_bad) begin
            err_q <= 1'b1;
            err_code_q <= ERR_CMP_EXCEEDS;
        end else begin
            err_q <= 1'b0;
        end
    end

    // ************************************************************
    // Waveform and pulse sequence
    // ************************************************************
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            line_q <= 1'b0;
            seq_q <= SEQ_IDLE;
            done_q <= REG_RESET;
        end else if (seq_start) begin
            line_q <= 1'b0;
            done_q <= REG_RESET;
            seq_q <= (total_next != REG_RESET) ? SEQ_RUN : SEQ_DONE;
        end else if (!enable_q) begin
            line_q <= 1'b0;
            seq_q <= SEQ_IDLE;
        end else if (phase_mode) begin
            // Fall wins when both compares are equal: zero width pulse
            if (sel_adv && (sel_cnt == fall_cmp)) begin
                line_q <= 1'b0;
            end else if (sel_adv && (sel_cnt == rise_cmp)) begin
                line_q <= 1'b1;
            end
        end else if (pulse_mode) begin
            unique case (seq_q)
                SEQ_IDLE: line_q <= 1'b0;
                SEQ_RUN: begin
                    if (sel_adv && line_q && (sel_cnt == fall_act_q)) begin
                        line_q <= 1'b0;
                        done_q <= done_q + ONE_WORD;
                        if (done_q + ONE_WORD == total_q) begin
                            seq_q <= SEQ_DONE;
                        end
                    end else if (sel_adv && !line_q && (sel_cnt == rise_act_q)) begin
                        line_q <= 1'b1;
                    end
                end
                SEQ_DONE: line_q <= 1'b0;
                default: seq_q <= SEQ_IDLE;
            endcase
        end else begin
            line_q <= 1'b0;
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            rdata_q <= REG_RESET;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd_in;
            if (reg_rd_in) begin
                unique case (reg_addr_in)
                    ADDR_ENABLE: rdata_q <= {31'h0000_0000, enable_q};
                    ADDR_SELECT: rdata_q <= select_q;
                    ADDR_OPTIONS: rdata_q <= options_q;
                    ADDR_FALL: rdata_q <= fall_stage_q;
                    ADDR_RISE: rdata_q <= rise_stage_q;
                    ADDR_PULSES: rdata_q <= total_q;
                    ADDR_RESULT: rdata_q <= pulse_mode ? done_q : REG_RESET;
                    ADDR_RESTART: rdata_q <= pulse_mode ? done_q : REG_RESET;
                endcase
            end
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reg_rvalid_out = rvalid_q;
    assign reg_err_out = err_q;
    assign reg_err_code_out = err_code_q;
    assign line_out = line_q;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_disable_low;
        !enable_q |=> !line_out;
    endproperty
    a_disable_low: assert property (p_disable_low) else $error("line high while disabled");

    property p_phase_rise;
        enable_q && phase_mode && sel_adv && (sel_cnt == rise_cmp) && (sel_cnt != fall_cmp) |=> line_out;
    endproperty
    a_phase_rise: assert property (p_phase_rise) else $error("no rise at rise compare");

    property p_phase_fall;
        enable_q && phase_mode && sel_adv && (sel_cnt == fall_cmp) |=> !line_out;
    endproperty
    a_phase_fall: assert property (p_phase_fall) else $error("no fall at fall compare");

    property p_fall_staged;
        phase_mode && wr_fall && !load_now |=> $stable(fall_act_q);
    endproperty
    a_fall_staged: assert property (p_fall_staged) else $error("fall write applied early");

    property p_load_pair;
        load_now |=> (fall_act_q == $past(fall_stage_q)) && (rise_act_q == $past(rise_stage_q)) &&
            (load_pend_q == $past(wr_rise && !cmp_bad));
    endproperty
    a_load_pair: assert property (p_load_pair) else $error("compares not loaded together");

    property p_no_midperiod;
        phase_mode && sel_run && !sel_start |=> $stable(fall_act_q) && $stable(rise_act_q);
    endproperty
    a_no_midperiod: assert property (p_no_midperiod) else $error("compare load mid period");

    property p_reject;
        (wr_fall || wr_rise) && (reg_wdata_in > sel_wrap) |=> reg_err_out && (reg_err_code_out == ERR_CMP_EXCEEDS);
    endproperty
    a_reject: assert property (p_reject) else $error("oversize compare not rejected");

    property p_phase_result;
        reg_rd_in && !pulse_mode && (reg_addr_in == ADDR_RESULT) |=> reg_rvalid_out && (reg_rdata_out == REG_RESET);
    endproperty
    a_phase_result: assert property (p_phase_result) else $error("phase mode result not zero");

    property p_seq_start;
        pulse_mode && wr_pulses |=> (done_q == REG_RESET) && !line_out ##1 (done_q == REG_RESET);
    endproperty
    a_seq_start: assert property (p_seq_start) else $error("pulse write did not restart");

    property p_pulse_result;
        reg_rd_in && pulse_mode && (reg_addr_in == ADDR_RESULT) |=> reg_rdata_out == $past(done_q);
    endproperty
    a_pulse_result: assert property (p_pulse_result) else $error("result not completed count");

    property p_restart;
        rd_restart && !wr_pulses |=> (reg_rdata_out == $past(done_q)) && (done_q == REG_RESET);
    endproperty
    a_restart: assert property (p_restart) else $error("restart read wrong");

    property p_done_low;
        enable_q && pulse_mode && (seq_q == SEQ_DONE) && !seq_start |=> !line_out;
    endproperty
    a_done_low: assert property (p_done_low) else $error("line high after last pulse");

endmodule

// file: ppg_line_probe.sv
`timescale 1ns/10ps
module ppg_line_probe (
    // Clock, line and clear
    input wire logic clk_sys_in,
    input wire logic line_in,
    input wire logic clear_in,
    // Edge tally
    output logic [15:0] rise_count_out
);
    logic line_q;
    // ************************************************************
    // Far-side counter input, tallies rising edges only
    // ************************************************************
    always_ff @(posedge clk_sys_in) begin
        line_q <= line_in;
        if (clear_in) begin
            rise_count_out <= 16'h0000;
        end else if (line_in && !line_q) begin
            rise_count_out <= rise_count_out + 16'h0001;
        end
    end
endmodule

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
    import ppg_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [TB_NUM-1:0] tb_en = '0;
    logic [TB_NUM-1:0][DIV_W-1:0] tb_div = '0;
    logic [TB_NUM-1:0][TB_W-1:0] tb_wrap = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata, rv;
    logic rvalid, err, err_seen, line;
    logic clr = 1'b1;
    logic [15:0] err_code, rises;
    int fail_count = 0;
    int checked = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    ppg_line i_ppg_line (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .tb_enable_in(tb_en),
        .tb_divider_in(tb_div), .tb_wrap_in(tb_wrap), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .reg_err_out(err),
        .reg_err_code_out(err_code), .line_out(line));
    ppg_line_probe i_ppg_line_probe (.clk_sys_in(clk_sys_in), .line_in(line), .clear_in(clr),
        .rise_count_out(rises));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(logic [ADDR_W-1:0] a, logic [31:0] d);
        @(negedge clk_sys_in);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk_sys_in);
        err_seen = err;
        wr = 1'b0;
    endtask
    // Missing rvalid turns the data unknown so the compare fails
    task automatic reg_rd(logic [ADDR_W-1:0] a);
        @(negedge clk_sys_in);
        rd = 1'b1;
        addr = a;
        @(negedge clk_sys_in);
        rv = (rvalid === 1'b1) ? rdata : 'x;
        rd = 1'b0;
    endtask
    task automatic settle(int n);
        @(negedge clk_sys_in);
        clr = 1'b1;
        @(negedge clk_sys_in);
        clr = 1'b0;
        repeat (n) @(negedge clk_sys_in);
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_phase();
        tb_wrap[0] = 32'h0000_000A;
        // Wrap lands while stopped, so the run starts on it and not on the old widest count
        @(negedge clk_sys_in);
        tb_en[0] = 1'b1;
        reg_wr(ADDR_SELECT, PHASE_INDEX);
        reg_wr(ADDR_OPTIONS, 32'h0000_0000);
        reg_wr(ADDR_FALL, 32'h0000_0006);
        reg_wr(ADDR_RISE, 32'h0000_0002);
        reg_wr(ADDR_ENABLE, ONE_WORD);
        settle(250);
        check("phase_rises", 32'(rises >= 16'd18 && rises <= 16'd21), ONE_WORD);
        reg_rd(ADDR_RESULT);
        check("phase_result", rv, REG_RESET);
        reg_rd(ADDR_RESTART);
        settle(125);
        check("phase_after_restart", 32'(rises >= 16'd9 && rises <= 16'd11), ONE_WORD);
        reg_wr(ADDR_FALL, 32'h0000_000A);
        check("edge_value_err", 32'(err_seen), 32'h0000_0000);
        reg_wr(ADDR_FALL, 32'h0000_000B);
        check("over_wrap_err", 32'(err_seen), ONE_WORD);
        check("over_wrap_code", 32'(err_code), 32'(ERR_CMP_EXCEEDS));
        reg_wr(ADDR_ENABLE, REG_RESET);
        settle(50);
        check("disabled_rises", 32'(rises), REG_RESET);
        check("disabled_line", 32'(line), REG_RESET);
    endtask
    task automatic t_pulse();
        tb_wrap[1] = 32'h0000_000A;
        tb_div[1] = 9'h002;
        @(negedge clk_sys_in);
        tb_en[1] = 1'b1;
        // Line already low from the disable, though each train start drives it low itself
        reg_wr(ADDR_SELECT, PULSE_INDEX);
        reg_wr(ADDR_OPTIONS, 32'h0000_0001);
        reg_wr(ADDR_FALL, 32'h0000_0002);
        reg_wr(ADDR_RISE, 32'h0000_0000);
        reg_wr(ADDR_ENABLE, ONE_WORD);
        reg_wr(ADDR_PULSES, 32'h0000_0003);
        settle(50);
        reg_rd(ADDR_RESULT);
        check("halfway_done", 32'(rv >= 32'h1 && rv <= 32'h2), ONE_WORD);
        // Tally held clear across the start edge, so early rises of the new train still count
        clr = 1'b1;
        reg_wr(ADDR_PULSES, 32'h0000_0003);
        clr = 1'b0;
        repeat (160) @(negedge clk_sys_in);
        check("train_rises", 32'(rises), 32'h0000_0003);
        check("train_line", 32'(line), REG_RESET);
        clr = 1'b1;
        reg_rd(ADDR_RESTART);
        clr = 1'b0;
        check("restart_read", rv, 32'h0000_0003);
        reg_rd(ADDR_RESULT);
        check("restart_cleared", rv, REG_RESET);
        repeat (160) @(negedge clk_sys_in);
        check("second_train", 32'(rises), 32'h0000_0003);
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk_sys_in);
        rst_b_in = 1'b1;
        t_phase();
        t_pulse();
        report_and_stop();
    end
    // Whole run is near 850 cycles, so this leaves ample slack
    initial begin
        repeat (6000) @(posedge clk_sys_in);
        fail_count++;
        report_and_stop();
    end
endmodule
